// ===== core/cfm_pkg.sv
// Constants, register map and carrier types for the charger fault and mask register bank.
// Assumes a register access port from an I2C slave engine that passes the 7-bit slave address along for the bank to decode.
// Behaviour
// - Input overvoltage flag sticks while condition lasts.
// - Input undervoltage flag reports once, clears on read.
// - Battery undervoltage flag sticks while condition lasts.
// - Battery overcurrent flag clears on fault register read.
// - Low nibble: four writable fault masks, reset zero.
// - Thermistor sense enable bit, writable, resets one.
// - Read-only thermistor fault code in bits six, five.
// - Interrupt content select bit, resets one.
// - Wake interrupt mask bit, resets zero.
// - Reset interrupt mask, reset output unaffected.
// - Safety timer interrupt mask bit, resets zero.
// - Deglitch clock stops in high-impedance mode without input supply or bus traffic.
// - Thermistor control at 0x02, reset 1xxx1000.
// - Fast-charge control at 0x03, reset 0x14.
// - Respond only to 7-bit slave address 6A.
// - Undefined register reads return 0xFF.
package cfm_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h6A;
  localparam logic [7:0] FAULT_ADDR = 8'h01;
  localparam logic [7:0] TSCTL_ADDR = 8'h02;
  localparam logic [7:0] FCC_ADDR = 8'h03;
  localparam logic [7:0] UNMAPPED_DATA = 8'hFF;
  localparam logic [3:0] FAULT_MASK_RST = 4'h0;
  localparam logic [7:0] TSCTL_RST = 8'h88;
  localparam logic [7:0] FCC_RST = 8'h14;
  localparam int THERMISTOR_SENSE_ENABLE_BIT = 7;
  localparam int INT_SEL_BIT = 3;
  localparam int WAKE_M_BIT = 2;
  localparam int RESET_M_BIT = 1;
  localparam int TIMER_M_BIT = 0;
  localparam int HZ_BIT = 0;
  localparam int DEGLITCH_NS = 1000;
  localparam int CLK_NS = 5;
  localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic in_ov;
    logic in_uv;
    logic bat_uv;
    logic bat_oc;
  } cfm_fault_s;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] slave;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cfm_req_s;
endpackage : cfm_pkg

// ===== core/cfm_deglitch.sv
// Deglitch filter for one raw fault condition.
// Assumes a one-cycle count enable that the parent stops while counting is not allowed.
`timescale 1ns/1ps
module cfm_deglitch #(
  parameter int COUNT = 200
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cnt_en_i,
  input wire logic raw_i,
  output logic level_o
);
  initial begin
    if (COUNT < 1 || COUNT > 65535) begin
      $error("cfm_deglitch COUNT out of range");
    end
  end
  logic [15:0] cnt_r;
  logic level_r;
  wire logic differ = raw_i != level_r;
  wire logic done = cnt_r == 16'(COUNT - 1);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 16'h0000;
      level_r <= 1'b0;
    end else if (!differ) begin
      cnt_r <= 16'h0000;
    end else if (cnt_en_i) begin
      cnt_r <= done ? 16'h0000 : cnt_r + 16'h0001;
      if (done) begin
        level_r <= raw_i;
      end
    end
  end
  assign level_o = level_r;
endmodule : cfm_deglitch

// ===== core/cfm_regs.sv
// Fault flags, fault masks, thermistor control and fast-charge control registers.
// Assumes a register request port from an I2C slave engine, one strobe per byte, with
// the slave address of the transaction alongside; raw conditions are synchronous.
`timescale 1ns/1ps
module cfm_regs #(
  parameter int DEGLITCH_COUNT = cfm_pkg::DEGLITCH_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire cfm_pkg::cfm_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire cfm_pkg::cfm_fault_s raw_fault_i,
  input wire logic vin_present_i,
  input wire logic i2c_busy_i,
  input wire logic [1:0] ts_code_i,
  input wire logic charge_status_evt_i,
  input wire logic wake_evt_i,
  input wire logic reset_evt_i,
  input wire logic timer_fault_i,
  output logic ts_sense_en_o,
  output logic [7:0] fast_charge_o,
  output logic high_impedance_mode_o,
  output logic int_o,
  output logic pushbutton_reset_o
);
  initial begin
    if (DEGLITCH_COUNT < 1) begin
      $error("cfm_regs DEGLITCH_COUNT must be positive");
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // Decode. Requests to another slave address are ignored entirely.
  wire logic sel = req_i.slave == cfm_pkg::SLAVE_ADDR;
  wire logic rd = req_i.rd && sel;
  wire logic wr = req_i.wr && sel;
  wire logic hit_fault = req_i.addr == cfm_pkg::FAULT_ADDR;
  wire logic hit_ts = req_i.addr == cfm_pkg::TSCTL_ADDR;
  wire logic hit_fcc = req_i.addr == cfm_pkg::FCC_ADDR;
  wire logic rd_fault = rd && hit_fault;
  //////////////////////////////////////////////////////////////////////////////////////////
  // Deglitch. The count enable stops in high-impedance mode to save power, unless the
  // battery side is active with bus traffic or the input supply is present.
  logic [7:0] fcc_r;
  wire logic hz = fcc_r[cfm_pkg::HZ_BIT];
  wire logic cnt_en = !hz || vin_present_i || i2c_busy_i;
  logic [3:0] raw_vec;
  logic [3:0] deg;
  assign raw_vec = raw_fault_i;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_deg
      cfm_deglitch #(.COUNT(DEGLITCH_COUNT)) u_deg (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .cnt_en_i(cnt_en),
        .raw_i(raw_vec[g]),
        .level_o(deg[g])
      );
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////////////////////////
  // Flags. Bits 3,1 (input OV, battery UV) follow the condition; bits 2,0 latch the event
  // and clear on read, with a new event in the read cycle winning over the clear.
  logic [3:0] flag_r;
  logic [3:0] deg_d_r;
  wire logic [3:0] rise = deg & ~deg_d_r;
  wire logic [3:0] keep = flag_r & {4{~rd_fault}};
  logic [3:0] flag_nxt;
  assign flag_nxt[3] = deg[3] || (keep[3] && deg[3]);
  assign flag_nxt[2] = rise[2] || keep[2];
  assign flag_nxt[1] = deg[1];
  assign flag_nxt[0] = rise[0] || keep[0];
  logic [3:0] mask_r;
  logic [7:0] ts_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_r <= 4'h0;
      deg_d_r <= 4'h0;
    end else begin
      flag_r <= flag_nxt;
      deg_d_r <= deg;
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // Writable registers.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_r <= cfm_pkg::FAULT_MASK_RST;
      ts_r <= cfm_pkg::TSCTL_RST;
      fcc_r <= cfm_pkg::FCC_RST;
    end else if (wr) begin
      if (hit_fault) begin
        mask_r <= req_i.wdata[3:0];
      end
      if (hit_ts) begin
        ts_r <= {req_i.wdata[7], 3'h0, req_i.wdata[3:0]};
      end
      if (hit_fcc) begin
        fcc_r <= req_i.wdata;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // Read path. Bit 4 of thermistor control is reserved and reads zero.
  wire logic [7:0] fault_view = {flag_r, mask_r};
  wire logic [7:0] ts_view = {ts_r[7], ts_code_i, 1'b0, ts_r[3:0]};
  wire logic [7:0] rd_mux = hit_fault ? fault_view :
                            hit_ts ? ts_view :
                            hit_fcc ? fcc_r :
                            cfm_pkg::UNMAPPED_DATA;
  logic [7:0] rdata_r;
  logic rvalid_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd;
      if (rd) begin
        rdata_r <= rd_mux;
      end
    end
  end
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  //////////////////////////////////////////////////////////////////////////////////////////
  // Interrupt. Masks gate the pin only; the flags above never look at them.
  wire logic fault_irq = |(flag_r & ~mask_r);
  wire logic stat_irq = ts_r[cfm_pkg::INT_SEL_BIT] && charge_status_evt_i;
  wire logic wake_irq = wake_evt_i && !ts_r[cfm_pkg::WAKE_M_BIT];
  wire logic rst_irq = reset_evt_i && !ts_r[cfm_pkg::RESET_M_BIT];
  wire logic tmr_irq = timer_fault_i && !ts_r[cfm_pkg::TIMER_M_BIT];
  logic int_r;
  logic prst_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_r <= 1'b0;
      prst_r <= 1'b0;
    end else begin
      int_r <= fault_irq || stat_irq || wake_irq || rst_irq || tmr_irq;
      prst_r <= reset_evt_i;
    end
  end
  assign int_o = int_r;
  assign pushbutton_reset_o = prst_r;
  assign ts_sense_en_o = ts_r[cfm_pkg::THERMISTOR_SENSE_ENABLE_BIT];
  assign fast_charge_o = fcc_r;
  assign high_impedance_mode_o = hz;
  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  a_ov_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
    deg[3] |=> flag_r[3])
    else $error("overvoltage flag dropped");
  a_uv_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rise[2] |=> flag_r[2])
    else $error("undervoltage event lost");
  a_uv_kept: assert property (@(posedge clk_i) disable iff (!resetn_i)
    flag_r[2] && !rd_fault |=> flag_r[2])
    else $error("undervoltage flag dropped unread");
  a_uv_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_fault && !rise[2] |=> !flag_r[2])
    else $error("undervoltage flag kept");
  a_batuv_follow: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1 |=> flag_r[1] == $past(deg[1]))
    else $error("battery uv flag wrong");
  a_oc_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rise[0] |=> flag_r[0])
    else $error("overcurrent event lost");
  a_oc_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_fault && !rise[0] |=> !flag_r[0])
    else $error("overcurrent flag kept");
  a_set_wins: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rise[0] && rd_fault |=> flag_r[0])
    else $error("event lost on read");
  a_mask_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && hit_fault |=> mask_r == $past(req_i.wdata[3:0]))
    else $error("mask write lost");
  a_ts_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && hit_ts |=> ts_r[7] == $past(req_i.wdata[7]) && ts_r[6:4] == 3'h0 &&
      ts_r[3:0] == $past(req_i.wdata[3:0]))
    else $error("thermistor control write wrong");
  a_ts_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd && hit_ts |=> rdata_o[6:5] == $past(ts_code_i) && !rdata_o[4])
    else $error("thermistor code read wrong");
  a_fcc_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && hit_fcc |=> fcc_r == $past(req_i.wdata))
    else $error("fcc write lost");
  a_fcc_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd && hit_fcc |=> rdata_o == $past(fcc_r))
    else $error("fcc read wrong");
  a_unmapped_ff: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd && !hit_fault && !hit_ts && !hit_fcc |=> rvalid_o && rdata_o == cfm_pkg::UNMAPPED_DATA)
    else $error("unmapped read not FF");
  a_addr_filter: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.rd && !sel |=> !rvalid_o)
    else $error("foreign address answered");
  a_foreign_wr: assert property (@(posedge clk_i) disable iff (!resetn_i)
    req_i.wr && !sel |=> $stable(fcc_r) && $stable(ts_r) && $stable(mask_r))
    else $error("foreign address written");
  a_mask_gates: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flag_r & ~mask_r) != 4'h0 |=> int_o)
    else $error("unmasked fault no irq");
  a_stat_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ts_r[cfm_pkg::INT_SEL_BIT] && charge_status_evt_i |=> int_o)
    else $error("charge status irq missing");
  a_wake_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wake_evt_i && !ts_r[cfm_pkg::WAKE_M_BIT] |=> int_o)
    else $error("wake irq missing");
  a_rst_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    reset_evt_i && !ts_r[cfm_pkg::RESET_M_BIT] |=> int_o)
    else $error("reset irq missing");
  a_reset_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
    1'b1 |=> pushbutton_reset_o == $past(reset_evt_i))
    else $error("reset output masked");
  a_timer_irq: assert property (@(posedge clk_i) disable iff (!resetn_i)
    timer_fault_i && !ts_r[cfm_pkg::TIMER_M_BIT] |=> int_o)
    else $error("timer irq missing");
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (flag_r & ~mask_r) == 4'h0 && !(ts_r[cfm_pkg::INT_SEL_BIT] && charge_status_evt_i) &&
      !(wake_evt_i && !ts_r[cfm_pkg::WAKE_M_BIT]) &&
      !(reset_evt_i && !ts_r[cfm_pkg::RESET_M_BIT]) &&
      !(timer_fault_i && !ts_r[cfm_pkg::TIMER_M_BIT]) |=> !int_o)
    else $error("masked source raised irq");
  a_hz_freeze: assert property (@(posedge clk_i) disable iff (!resetn_i)
    hz && !vin_present_i && !i2c_busy_i |=> deg == $past(deg))
    else $error("deglitch ran");
endmodule : cfm_regs

// ===== testbench/cfm_host.sv
// Host model issuing single-byte register accesses on the request port.
// Assumes the bank's clock; request fields change on falling edges only.
`timescale 1ns/1ps
module cfm_host (
  input wire logic clk_i,
  output cfm_pkg::cfm_req_s req_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial req_o = '0;
  ////////////////////////////////////////
  // Released strobes are cleared and the other fields inverted so a stale request never looks valid.
  // The answer is taken while it stands; an idle cycle then lets registered outputs follow.
  task automatic xfer(input logic wr, input logic [6:0] sl, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    @(negedge clk_i);
    req_o = {wr, ~wr, sl, a, d};
    @(negedge clk_i);
    ok = rvalid_i;
    q = rdata_i;
    req_o = {2'b00, ~sl, ~a, ~d};
    @(negedge clk_i);
  endtask : xfer
  // A status fault with no flag set here means an input current limit fault.
  function automatic logic is_current_limit(input logic [7:0] flags);
    return flags[7:4] == 4'h0;
  endfunction : is_current_limit
endmodule : cfm_host

// ===== testbench/charger_fault_mask_registers_bench.sv
// Self-checking bench for the fault, mask and control register bank.
// Assumes a deglitch count of 3 and the host model on the request port.
`timescale 1ns/1ps
module charger_fault_mask_registers_bench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  cfm_pkg::cfm_req_s req;
  cfm_pkg::cfm_fault_s flt = '0;
  logic vin = 1'b1, busy = 1'b0, chg = 1'b0, wake = 1'b0, rst_evt = 1'b0, tmr = 1'b0;
  logic [1:0] code = 2'h0;
  logic thermistor_sense_enable, hz, irq, pb_rst, rvalid, ok;
  logic [7:0] fcc, rdata, q, d;
  int bad_count = 0;
  int samples_checked = 0;
  integer seed = 32'hfaf4c123;
  always #2.5 clk_i = ~clk_i;
  cfm_regs #(.DEGLITCH_COUNT(3)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .raw_fault_i(flt), .vin_present_i(vin),
    .i2c_busy_i(busy), .ts_code_i(code), .charge_status_evt_i(chg), .wake_evt_i(wake),
    .reset_evt_i(rst_evt), .timer_fault_i(tmr), .ts_sense_en_o(thermistor_sense_enable),
    .fast_charge_o(fcc), .high_impedance_mode_o(hz), .int_o(irq),
    .pushbutton_reset_o(pb_rst));
  cfm_host i_host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_host.xfer(1'b0, cfm_pkg::SLAVE_ADDR, a, 8'h00, q, ok);
    chk("rvalid", 8'h01, {7'h0, ok});
    chk(what, exp, q);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_host.xfer(1'b1, cfm_pkg::SLAVE_ADDR, a, v, q, ok);
  endtask : wr
  function automatic logic [7:0] ts_exp(input logic [7:0] v, input logic [1:0] c);
    return {v[7], c, 1'b0, v[3:0]};
  endfunction : ts_exp
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////
  // A hang anywhere below is cut short here rather than running forever.
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
  initial begin
    code = 2'($random(seed));
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    chk("ts_sense_en", 8'h01, {7'h0, thermistor_sense_enable});
    chk("fast_charge", cfm_pkg::FCC_RST, fcc);
    rd(cfm_pkg::TSCTL_ADDR, ts_exp(cfm_pkg::TSCTL_RST, code), "tsctl reset");
    rd(cfm_pkg::FCC_ADDR, cfm_pkg::FCC_RST, "fcc reset");
    rd(cfm_pkg::FAULT_ADDR, 8'h00, "fault reset");
    chk("current limit", 8'h01, {7'h0, i_host.is_current_limit(q)});
    rd(8'h07, cfm_pkg::UNMAPPED_DATA, "unmapped");
    i_host.xfer(1'b0, 7'h6B, cfm_pkg::FCC_ADDR, 8'h00, q, ok);
    chk("foreign slave", 8'h00, {7'h0, ok});
    wr(cfm_pkg::TSCTL_ADDR, 8'h08);
    chk("ts_sense off", 8'h00, {7'h0, thermistor_sense_enable});
    $display("test reset and map done");
    repeat (6) begin
      d = 8'($random(seed)) | 8'h80;
      code = 2'($random(seed));
      wr(cfm_pkg::FCC_ADDR, {d[7:1], 1'b0});
      chk("fast_charge out", {d[7:1], 1'b0}, fcc);
      wr(cfm_pkg::TSCTL_ADDR, d);
      rd(cfm_pkg::TSCTL_ADDR, ts_exp(d, code), "tsctl rw");
      wr(cfm_pkg::FAULT_ADDR, d);
      rd(cfm_pkg::FAULT_ADDR, {4'h0, d[3:0]}, "fault masks");
    end
    $display("test register access done");
    wr(cfm_pkg::TSCTL_ADDR, 8'h80);
    for (int i = 0; i < 4; i++) begin
      {chg, wake, rst_evt, tmr} = 4'h8 >> i;
      wr(cfm_pkg::TSCTL_ADDR, 8'h80 | (8'h08 >> i));
      chk("int masked", {7'h0, i == 0}, {7'h0, irq});
      wr(cfm_pkg::TSCTL_ADDR, 8'h80);
      chk("int open", {7'h0, i != 0}, {7'h0, irq});
      chk("pushbutton reset", {7'h0, rst_evt}, {7'h0, pb_rst});
    end
    {chg, wake, rst_evt, tmr} = 4'h0;
    $display("test interrupt masks done");
    wr(cfm_pkg::FAULT_ADDR, 8'h0F);
    flt = 4'hF;
    repeat (8) @(negedge clk_i);
    chk("int fault masked", 8'h00, {7'h0, irq});
    rd(cfm_pkg::FAULT_ADDR, 8'hFF, "fault first");
    rd(cfm_pkg::FAULT_ADDR, 8'hAF, "fault second");
    wr(cfm_pkg::FAULT_ADDR, 8'h00);
    chk("int fault open", 8'h01, {7'h0, irq});
    flt = 4'h0;
    repeat (8) @(negedge clk_i);
    rd(cfm_pkg::FAULT_ADDR, 8'h00, "fault gone");
    // The filtered overcurrent edge is timed to land on the edge that takes the read.
    flt.bat_oc = 1'b1;
    repeat (2) @(negedge clk_i);
    rd(cfm_pkg::FAULT_ADDR, 8'h00, "set during read");
    rd(cfm_pkg::FAULT_ADDR, 8'h10, "set kept");
    flt.bat_oc = 1'b0;
    repeat (8) @(negedge clk_i);
    $display("test fault flags done");
    vin = 1'b0;
    wr(cfm_pkg::FCC_ADDR, 8'h15);
    chk("hz", 8'h01, {7'h0, hz});
    flt.bat_uv = 1'b1;
    repeat (10) @(negedge clk_i);
    rd(cfm_pkg::FAULT_ADDR, 8'h00, "hz paused");
    vin = 1'b1;
    repeat (8) @(negedge clk_i);
    rd(cfm_pkg::FAULT_ADDR, 8'h20, "vin resumes");
    vin = 1'b0;
    busy = 1'b1;
    flt.bat_uv = 1'b0;
    repeat (8) @(negedge clk_i);
    rd(cfm_pkg::FAULT_ADDR, 8'h00, "busy resumes");
    $display("test high impedance done");
    print_verdict();
  end
endmodule : charger_fault_mask_registers_bench
